// ==== common/status_pkg.sv ====
// Constants shared by the status register bank and its helpers.
// Assumes a 32-bit AXI4-Lite register bus with word-aligned byte addresses.

package status_pkg;

    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_STATUS     = 8'h00;
    localparam logic [7:0] ADDR_IF_MODE    = 8'h04;
    localparam logic [7:0] ADDR_CONV_MODE  = 8'h08;
    localparam logic [7:0] ADDR_DATA       = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
    localparam logic [7:0] ADDR_IRQ_CLEAR  = 8'h14;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h18;

    // ------------------------------------------------------------
    // Status register layout
    // ------------------------------------------------------------
    localparam int         STAT_READY_BIT = 7;
    localparam int         STAT_RANGE_BIT = 6;
    localparam int         STAT_CRC_BIT   = 5;
    localparam int         STAT_INTEG_BIT = 4;
    localparam int         STAT_CHAN_LSB  = 0;
    localparam int         CHAN_W         = 3;
    localparam logic [7:0] STATUS_RESET   = 8'h80;

    // ------------------------------------------------------------
    // Interface mode and converter mode layout
    // ------------------------------------------------------------
    localparam int          IFM_APPEND_BIT  = 6;
    localparam int          IFM_CHECK_BIT   = 5;
    localparam logic [15:0] IF_MODE_RESET   = 16'h0000;
    localparam logic [15:0] CONV_MODE_RESET = 16'h2000;
    localparam int          MODE_W          = 16;

    // ------------------------------------------------------------
    // Data path
    // ------------------------------------------------------------
    localparam int          DATA_W    = 24;
    localparam logic [23:0] DATA_FULL = 24'hFFFFFF;
    localparam logic [23:0] DATA_ZERO = 24'h000000;
    localparam logic [2:0]  BYTES_PLAIN    = 3'h3;
    localparam logic [2:0]  BYTES_APPENDED = 3'h4;

    // ------------------------------------------------------------
    // Interrupt events
    // ------------------------------------------------------------
    localparam int IRQ_N         = 4;
    localparam int IRQ_NEW_DATA  = 0;
    localparam int IRQ_RANGE     = 1;
    localparam int IRQ_CRC       = 2;
    localparam int IRQ_INTEG     = 3;

    // ------------------------------------------------------------
    // AXI responses
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ==== hdl/axil_regs_slave.sv ====
// AXI4-Lite slave front end: turns bus handshakes into one-cycle
// register write and read strobes.
// Assumes the register owner answers a read strobe combinationally.
`timescale 1ns/1ps

module axil_regs_slave (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             wr_en,
    output logic [7:0]       wr_addr,
    output logic [31:0]      wr_data,
    output logic [3:0]       wr_strb,
    input  wire logic        wr_ok,
    output logic             rd_en,
    output logic [7:0]       rd_addr,
    input  wire logic [31:0] rd_data,
    input  wire logic        rd_ok
);

    logic aw_held;
    logic w_held;

    // ------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------
    // Address and data may arrive in either order; each is held until
    // both are present, then one write strobe fires and the response follows a cycle later.
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign wr_en         = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            wr_addr <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            wr_addr <= s_axi_awaddr;
        end else if (wr_en) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held  <= 1'b0;
            wr_data <= 32'h00000000;
            wr_strb <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held  <= 1'b1;
            wr_data <= s_axi_wdata;
            wr_strb <= s_axi_wstrb;
        end else if (wr_en) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= status_pkg::RESP_OKAY;
        end else if (wr_en) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? status_pkg::RESP_OKAY : status_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_en         = s_axi_arvalid && s_axi_arready;
    assign rd_addr       = s_axi_araddr;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= status_pkg::RESP_OKAY;
        end else if (rd_en) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_data;
            s_axi_rresp  <= rd_ok ? status_pkg::RESP_OKAY : status_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

// ==== hdl/event_flags.sv ====
// Sticky event flags with write-one-to-clear and an enable mask.
// Assumes set and clear are one-cycle pulses on the same clock.
`timescale 1ns/1ps

module event_flags #(
    parameter int N = 4
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [N-1:0] set,
    input  wire logic [N-1:0] clear,
    input  wire logic [N-1:0] enable,
    output logic [N-1:0]      flags,
    output logic              irq
);

    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_flag
            // A set in the same cycle as a clear wins, so no event is lost
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    flags[i] <= 1'b0;
                end else if (set[i]) begin
                    flags[i] <= 1'b1;
                end else if (clear[i]) begin
                    flags[i] <= 1'b0;
                end
            end
        end
    endgenerate

    assign irq = |(flags & enable);

endmodule

// ==== hdl/adc_status_flags.sv ====
// Status register bank of a multiplexed converter: new-data, range,
// CRC and integrity flags, held result and channel, ready pin mirror.
// Assumes converter, CRC and serial logic run on aclk; only cs_n is a pin.
`timescale 1ns/1ps

module adc_status_flags (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite register bus
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Converter side
    input  wire logic        result_valid,
    input  wire logic [23:0] result_data,
    input  wire logic        result_over,
    input  wire logic        result_under,
    input  wire logic [2:0]  result_channel,
    input  wire logic        calib_done,
    output logic             conv_restart,
    output logic [15:0]      conv_mode,
    // CRC and integrity checkers
    input  wire logic        crc_write_fail,
    input  wire logic        reg_mismatch,
    output logic             integrity_check_en,
    // Serial port side
    input  wire logic        cs_n,
    input  wire logic        serial_read_active,
    input  wire logic        serial_read_bit,
    input  wire logic        serial_data_read,
    input  wire logic        serial_status_read,
    output logic             dout_ready_out,
    output logic             dout_ready_oe,
    output logic [31:0]      read_frame,
    output logic [2:0]       read_frame_bytes,
    // Interrupt
    output logic             irq
);

    logic        wr_en;
    logic [7:0]  wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic        wr_ok;
    logic        rd_en;
    logic [7:0]  rd_addr;
    logic [31:0] rd_data;
    logic        rd_ok;

    logic        ready_n;
    logic        range_err;
    logic        crc_err;
    logic        integ_err;
    logic [2:0]  held_channel;
    logic [23:0] data_reg;
    logic [15:0] if_mode;
    logic [7:0]  status;
    logic        append_status;

    logic        cs_meta;
    logic        cs_sync_n;

    logic        wr_if_mode;
    logic        wr_conv_mode;
    logic        rd_status;
    logic        rd_data_reg;
    logic        new_result;
    logic        range_now;

    logic [status_pkg::IRQ_N-1:0] irq_set;
    logic [status_pkg::IRQ_N-1:0] irq_clear;
    logic [status_pkg::IRQ_N-1:0] irq_enable;
    logic [status_pkg::IRQ_N-1:0] irq_flags;

    // ------------------------------------------------------------
    // Bus front end
    // ------------------------------------------------------------
    axil_regs_slave u_bus (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wr_en         (wr_en),
        .wr_addr       (wr_addr),
        .wr_data       (wr_data),
        .wr_strb       (wr_strb),
        .wr_ok         (wr_ok),
        .rd_en         (rd_en),
        .rd_addr       (rd_addr),
        .rd_data       (rd_data),
        .rd_ok         (rd_ok)
    );

    // ------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------
    assign wr_if_mode   = wr_en && (wr_addr == status_pkg::ADDR_IF_MODE);
    assign wr_conv_mode = wr_en && (wr_addr == status_pkg::ADDR_CONV_MODE);
    // Either port reading counts: the flags must not depend on which one the host used
    assign rd_status    = (rd_en && (rd_addr == status_pkg::ADDR_STATUS))
                          || serial_status_read;
    assign rd_data_reg  = (rd_en && (rd_addr == status_pkg::ADDR_DATA))
                          || serial_data_read;

    // Status is accepted but dropped; the flags are read-only
    always_comb begin
        unique case (wr_addr)
            status_pkg::ADDR_STATUS,
            status_pkg::ADDR_IF_MODE,
            status_pkg::ADDR_CONV_MODE,
            status_pkg::ADDR_IRQ_CLEAR,
            status_pkg::ADDR_IRQ_ENABLE: wr_ok = 1'b1;
            default:                     wr_ok = 1'b0;
        endcase
    end

    always_comb begin
        rd_ok   = 1'b1;
        rd_data = 32'h00000000;
        unique case (rd_addr)
            status_pkg::ADDR_STATUS:     rd_data[7:0] = status;
            status_pkg::ADDR_IF_MODE:    rd_data[15:0] = if_mode;
            status_pkg::ADDR_CONV_MODE:  rd_data[15:0] = conv_mode;
            status_pkg::ADDR_DATA:       rd_data[23:0] = data_reg;
            status_pkg::ADDR_IRQ_STATUS: rd_data[3:0] = irq_flags;
            status_pkg::ADDR_IRQ_ENABLE: rd_data[3:0] = irq_enable;
            default:                     rd_ok = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Mode registers
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            if_mode <= status_pkg::IF_MODE_RESET;
        end else if (wr_if_mode) begin
            if_mode <= wr_data[15:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            conv_mode    <= status_pkg::CONV_MODE_RESET;
            conv_restart <= 1'b0;
        end else begin
            conv_restart <= wr_conv_mode;
            if (wr_conv_mode) begin
                conv_mode <= wr_data[15:0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_enable <= '0;
        end else if (wr_en && (wr_addr == status_pkg::ADDR_IRQ_ENABLE)) begin
            irq_enable <= wr_data[status_pkg::IRQ_N-1:0];
        end
    end

    assign append_status      = if_mode[status_pkg::IFM_APPEND_BIT];
    assign integrity_check_en = if_mode[status_pkg::IFM_CHECK_BIT];

    // ------------------------------------------------------------
    // Result capture
    // ------------------------------------------------------------
    assign new_result = result_valid || calib_done;
    assign range_now  = result_over || result_under;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data_reg     <= status_pkg::DATA_ZERO;
            held_channel <= '0;
        end else if (result_valid) begin
            held_channel <= result_channel;
            if (result_over) begin
                data_reg <= status_pkg::DATA_FULL;
            end else if (result_under) begin
                data_reg <= status_pkg::DATA_ZERO;
            end else begin
                data_reg <= result_data;
            end
        end
    end

    // ------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------
    // Flag is active low; a new result outranks a read or restart in the
    // same cycle so that result is never reported as already consumed.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ready_n <= status_pkg::STATUS_RESET[status_pkg::STAT_READY_BIT];
        end else if (new_result) begin
            ready_n <= 1'b0;
        end else if (rd_data_reg || wr_conv_mode) begin
            ready_n <= 1'b1;
        end
    end

    // Recomputed on every result_valid, so a clean result clears it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            range_err <= status_pkg::STATUS_RESET[status_pkg::STAT_RANGE_BIT];
        end else if (result_valid) begin
            range_err <= range_now;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            crc_err <= status_pkg::STATUS_RESET[status_pkg::STAT_CRC_BIT];
        end else if (crc_write_fail) begin
            crc_err <= 1'b1;
        end else if (rd_status) begin
            crc_err <= 1'b0;
        end
    end

    // Only clearing the check enable clears it; reads leave it alone
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            integ_err <= status_pkg::STATUS_RESET[status_pkg::STAT_INTEG_BIT];
        end else if (!integrity_check_en) begin
            integ_err <= 1'b0;
        end else if (reg_mismatch) begin
            integ_err <= 1'b1;
        end
    end

    always_comb begin
        status = '0;
        status[status_pkg::STAT_READY_BIT] = ready_n;
        status[status_pkg::STAT_RANGE_BIT] = range_err;
        status[status_pkg::STAT_CRC_BIT]   = crc_err;
        status[status_pkg::STAT_INTEG_BIT] = integ_err;
        status[status_pkg::STAT_CHAN_LSB +: status_pkg::CHAN_W] = held_channel;
    end

    // ------------------------------------------------------------
    // Serial read frame and ready pin
    // ------------------------------------------------------------
    // Status rides in the low byte after the result
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            read_frame       <= {status_pkg::DATA_ZERO, status_pkg::STATUS_RESET};
            read_frame_bytes <= status_pkg::BYTES_PLAIN;
        end else begin
            read_frame       <= {data_reg, status};
            read_frame_bytes <= append_status ? status_pkg::BYTES_APPENDED
                                              : status_pkg::BYTES_PLAIN;
        end
    end

    // Chip select is a pin: two flops before use
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cs_meta   <= 1'b1;
            cs_sync_n <= 1'b1;
        end else begin
            cs_meta   <= cs_n;
            cs_sync_n <= cs_meta;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dout_ready_out <= 1'b1;
            dout_ready_oe  <= 1'b0;
        end else begin
            dout_ready_oe  <= !cs_sync_n;
            dout_ready_out <= serial_read_active ? serial_read_bit : ready_n;
        end
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    always_comb begin
        irq_set = '0;
        irq_set[status_pkg::IRQ_NEW_DATA] = new_result;
        irq_set[status_pkg::IRQ_RANGE]    = result_valid && range_now;
        irq_set[status_pkg::IRQ_CRC]      = crc_write_fail;
        irq_set[status_pkg::IRQ_INTEG]    = integrity_check_en && reg_mismatch;
    end

    assign irq_clear = (wr_en && (wr_addr == status_pkg::ADDR_IRQ_CLEAR))
                       ? wr_data[status_pkg::IRQ_N-1:0] : '0;

    event_flags #(
        .N (status_pkg::IRQ_N)
    ) u_events (
        .aclk    (aclk),
        .aresetn (aresetn),
        .set     (irq_set),
        .clear   (irq_clear),
        .enable  (irq_enable),
        .flags   (irq_flags),
        .irq     (irq)
    );

endmodule

// ==== tb/adc_status_flags_monitor.sv ====
// Port checker of the status bank, bound to adc_status_flags.
// Assumes read_frame shows the status register within two cycles.
`timescale 1ns/1ps
module adc_status_flags_monitor (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_bvalid,
    input wire logic        result_valid,
    input wire logic        result_over,
    input wire logic        result_under,
    input wire logic [2:0]  result_channel,
    input wire logic        crc_write_fail,
    input wire logic        integrity_check_en,
    input wire logic        conv_restart,
    input wire logic [31:0] read_frame
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_new; result_valid |-> ##2 !read_frame[7]; endproperty
    a_new: assert property (p_new) else $error("new data");
    property p_ovr; result_valid && result_over |-> ##2 read_frame[31:6] == 26'h3FFFFFD;
    endproperty
    a_ovr: assert property (p_ovr) else $error("overrange");
    property p_und; result_valid && result_under && !result_over
        |-> ##2 read_frame[31:6] == 26'h1; endproperty
    a_und: assert property (p_und) else $error("underrange");
    property p_cln; result_valid && !result_over && !result_under |-> ##2 !read_frame[6];
    endproperty
    a_cln: assert property (p_cln) else $error("range clear");
    property p_chn; logic [2:0] c;
        (result_valid, c = result_channel) |-> ##2 read_frame[2:0] == c; endproperty
    a_chn: assert property (p_chn) else $error("channel");
    property p_crc; crc_write_fail |-> ##2 read_frame[5]; endproperty
    a_crc: assert property (p_crc) else $error("crc flag");
    property p_int; !integrity_check_en [*3] |=> !read_frame[4]; endproperty
    a_int: assert property (p_int) else $error("integrity");
    property p_rst; conv_restart |-> s_axi_bvalid; endproperty
    a_rst: assert property (p_rst) else $error("restart");
    c_ovr: cover property (result_valid && result_over);
    c_crc: cover property (crc_write_fail);
    c_rst: cover property (conv_restart);
endmodule
bind adc_status_flags adc_status_flags_monitor adc_status_flags_monitor_i (.*);

// ==== tb/host_serial_model.sv ====
// Host side of the serial port: chip select and data register reads.
// Assumes the bench asks for one read at a time.
`timescale 1ns/1ps
module host_serial_model (
    input  wire logic aclk,
    input  wire logic sel,
    input  wire logic rd,
    output logic      cs_n,
    output logic      serial_read_active,
    output logic      serial_data_read
);
    logic [2:0] left = 3'h0;
    assign serial_read_active = left != 3'h0;
    assign serial_data_read = left == 3'h1;
    // Read data CRC is judged on this side; the bank flags write faults only
    always @(posedge aclk) begin
        cs_n <= !sel;
        left <= rd ? 3'h4 : left - {2'h0, left != 3'h0};
    end
endmodule

// ==== tb/adc_status_flags_test.sv ====
// Bench of the status bank: bus tasks, a row loop, then event tests.
// Assumes the host serial model drives the pin side.
`timescale 1ns/1ps
module adc_status_flags_test;
    logic        aclk = 1'b0, aresetn = 1'b0, rv = 1'b0, sel = 1'b0, rd = 1'b0;
    logic        awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
    logic        awr, wr, bv, arr, rvd, oe, pin, irq, sra, sdr, cs_n;
    logic [1:0]  bresp, rresp, resp;
    logic [2:0]  ev = 3'h0, nby;
    logic [7:0]  awa = 8'h00, ara = 8'h00;
    logic [28:0] res = 29'h0;
    logic [31:0] wd = 32'h0, rdata, frame, got;
    logic [4:0]  hs;
    logic [15:0] cm;
    // {over, under, channel, raw, expected data, expected status}
    logic [63:0] rows [4] = '{64'h01_123456_123456_01, 64'h17_ABCDEF_FFFFFF_47,
                              64'h08_000123_000000_40, 64'h05_7FFFFF_7FFFFF_05};
    int          miscompares = 0, comparisons = 0, i, n;
    always #20 aclk = !aclk;
    adc_status_flags adc_status_flags_i (.aclk, .aresetn, .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvd), .s_axi_rready(rry),
        .result_valid(rv), .result_data(res[23:0]), .result_over(res[28]),
        .result_under(res[27]), .result_channel(res[26:24]), .calib_done(ev[0]),
        .conv_restart(), .conv_mode(cm), .crc_write_fail(ev[1]), .reg_mismatch(ev[2]),
        .integrity_check_en(), .cs_n, .serial_read_active(sra), .serial_read_bit(1'b1),
        .serial_data_read(sdr), .serial_status_read(1'b0), .dout_ready_out(pin),
        .dout_ready_oe(oe), .read_frame(frame), .read_frame_bytes(nby), .irq);
    host_serial_model host_serial_model_i (.aclk, .sel, .rd, .cs_n,
        .serial_read_active(sra), .serial_data_read(sdr));
    task automatic check(input string nm, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic report_and_stop(input int extra);
        miscompares += extra;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Ready is sampled at the falling edge so no edge race decides a handshake
    task automatic bus(input logic r, input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        if (r) {ara, arv, rry} <= {a, 2'b11};
        else {awa, wd, awv, wv, bry} <= {a, d, 3'b111};
        for (n = 0; n < 50; n++) begin
            @(negedge aclk);
            hs = {awv & awr, wv & wr, arv & arr, bv, rvd};
            {got, resp} = {rdata, r ? rresp : bresp};
            @(posedge aclk);
            {awv, wv, arv} <= {awv, wv, arv} & ~hs[4:2];
            if (hs[1:0] != 2'b00) break;
        end
        {bry, rry} <= 2'b00;
        if (n == 50) report_and_stop(1);
    endtask
    task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
        bus(1'b1, a, 32'h0);
        check(nm, got, e);
    endtask
    task automatic fire(input logic [3:0] m, input logic [28:0] v);
        @(posedge aclk);
        {rv, ev, res} <= {m, v};
        @(posedge aclk);
        {rv, ev} <= 4'h0;
    endtask
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rc("st", 8'h00, 32'h80);
        bus(1'b0, 8'h00, 32'hFF);
        check("bresp", resp, 32'h0);
        rc("st", 8'h00, 32'h80);
        rc("bad", 8'h20, 32'h0);
        check("rresp", resp, 32'h2);
        $display("reset test done");
        for (i = 0; i < 4; i++) begin
            fire(4'h8, rows[i][60:32]);
            rc("st", 8'h00, rows[i][7:0]);
            rc("dat", 8'h0C, rows[i][31:8]);
            rc("st", 8'h00, rows[i][7:0] | 8'h80);
        end
        $display("row test done");
        fire(4'h2, 29'h0);
        bus(1'b0, 8'h18, 32'h4);
        @(negedge aclk);
        check("irq", irq, 32'h1);
        rc("st", 8'h00, 32'hA5);
        rc("st", 8'h00, 32'h85);
        bus(1'b0, 8'h14, 32'h4);
        bus(1'b0, 8'h04, 32'h60);
        fire(4'h4, 29'h0);
        rc("st", 8'h00, 32'h95);
        check("irq", irq, 32'h0);
        check("bytes", nby, 32'h4);
        check("frame", frame, 32'h7FFFFF95);
        bus(1'b0, 8'h04, 32'h0);
        rc("st", 8'h00, 32'h85);
        fire(4'h8, 29'h03123456);
        bus(1'b0, 8'h08, 32'h0100);
        check("mode", cm, 32'h0100);
        rc("st", 8'h00, 32'h83);
        fire(4'h1, 29'h0);
        rc("st", 8'h00, 32'h03);
        sel <= 1'b1;
        repeat (8) @(negedge aclk);
        check("pin", {oe, pin}, 32'h2);
        @(posedge aclk);
        rd <= 1'b1;
        @(posedge aclk);
        rd <= 1'b0;
        // Mid-read the pin shows the register bit, not the still-low flag
        repeat (2) @(negedge aclk);
        check("rdpin", {oe, pin}, 32'h3);
        repeat (10) @(negedge aclk);
        check("pin", {oe, pin}, 32'h3);
        $display("event test done");
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rc("st", 8'h00, 32'h80);
        $display("restart test done");
        report_and_stop(0);
    end
endmodule
